//--- dsv_validator.sv
// Data set validator: APB-staged data set checking with error mailbox byte
//
// What this block does
// - Check every entered data set, number errors
// - Failed transfer puts error in mailbox byte
// - Identity string mismatch gives error 2
// - Bad or used identification number: error 3
// - Interrupt line above 4 gives error 8
// - Line/module change locked while machine data
// - Entry only with job 64 or 65, else 200
// - Entry/deletion needs programmer or controller mode
// - Machine number bad or other axis: 3
// - Other number or protected change: error 4
// - Module number bad or mismatched: error 5
// - Axis 1-3 else 6; measuring 1-3 else 8
// - Function 1-2 else 9; accuracy 1-4 else 10
// - Coordinate effect 1-3 else error 16
// - Revolution interrupt on linear axis: 12
// - Encoder type rules, borrowed only axis 3
// - Increments per revolution per encoder kind: 22
// - Path per revolution 1 to 1e8: 23
// - Revolutions 1-4096, kind rules, else 24
// - Serial encoder range must cover travel: 28
`include "dsv_defs.svh"

module dsv_validator #(
	parameter int unsigned NUM_AXES = 3
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [7:0] mbox_err_code,
	output dsv_pkg::dsv_state_t seq_state
);
	import dsv_pkg::*;

	// ===========================================================
	// Helper functions
	// Zero is not a power of two here
	function automatic logic is_pow2(input logic [31:0] v);
		is_pow2 = (v != 32'h0) && ((v & (v - 32'h1)) == 32'h0);
	endfunction

	// Types 8 and 9 reuse an incremental encoder of axis 1 or 2
	function automatic dsv_enc_t enc_kind(input logic [3:0] t);
		if (t == 4'h1 || t == 4'h2 || t == 4'h8 || t == 4'h9) begin
			enc_kind = DSV_ENC_INCR;
		end else if (t == 4'h3 || t == 4'h4) begin
			enc_kind = DSV_ENC_SINGLE;
		end else if (t >= 4'h5 && t <= 4'h7) begin
			enc_kind = DSV_ENC_MULTI;
		end else begin
			enc_kind = DSV_ENC_BAD;
		end
	endfunction

	// ===========================================================
	// Declarations
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r;
	logic [7:0] err_r;
	dsv_state_t state_r, state_nxt;
	logic [7:0] job_r;
	logic del_r;
	logic [1:0] mode_r;
	logic [15:0] type_r;
	logic [31:0] ident_r, incr_r, path_r, trav_r, prot_r;
	logic [15:0] revs_r;
	dsv_hdr_t hdr_r;
	dsv_mcode_t mcode_r;
	logic sys_valid_r;
	logic [7:0] sys_num_r, sys_line_r, sys_mod_r;
	logic [NUM_AXES:1] mach_valid_r, mach_incr_r;
	logic [7:0] mach_num_r [1:NUM_AXES];
	logic [31:0] mach_prot_r [1:NUM_AXES];
	logic [7:0] chk_err;
	logic [31:0] rd_data;
	logic addr_ok;
	logic acc, wr, idle;

	assign acc = psel & penable & pready_r;
	assign wr = acc & pwrite;
	assign idle = (state_r == DSV_IDLE);

	// ===========================================================
	// APB slave: one wait state, so pready is a plain flop
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= psel & penable & ~pready_r;
			prdata_r <= rd_data;
			pslverr_r <= psel & penable & ~pready_r & ~addr_ok;
		end
	end

	// Read decode; unmapped offsets read zero with an error
	always_comb begin
		rd_data = 32'h0;
		addr_ok = 1'b1;
		if (paddr == `DSV_OFF_CTRL) begin
			rd_data = {16'h0, job_r, 8'h0};
		end else if (paddr == `DSV_OFF_MODE) begin
			rd_data = {30'h0, mode_r};
		end else if (paddr == `DSV_OFF_TYPE) begin
			rd_data = {16'h0, type_r};
		end else if (paddr == `DSV_OFF_IDENT) begin
			rd_data = ident_r;
		end else if (paddr == `DSV_OFF_HDR) begin
			rd_data = hdr_r;
		end else if (paddr == `DSV_OFF_MCODE) begin
			rd_data = mcode_r;
		end else if (paddr == `DSV_OFF_INCR) begin
			rd_data = incr_r;
		end else if (paddr == `DSV_OFF_PATH) begin
			rd_data = path_r;
		end else if (paddr == `DSV_OFF_REVS) begin
			rd_data = {16'h0, revs_r};
		end else if (paddr == `DSV_OFF_TRAV) begin
			rd_data = trav_r;
		end else if (paddr == `DSV_OFF_PROT) begin
			rd_data = prot_r;
		end else if (paddr == `DSV_OFF_STATUS) begin
			rd_data = 32'h0;
			rd_data[7:0] = err_r;
			rd_data[`DSV_ST_BUSY] = ~idle;
			rd_data[`DSV_ST_SYS] = sys_valid_r;
			rd_data[`DSV_ST_MACH_LSB +: NUM_AXES] = mach_valid_r;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// ===========================================================
	// Staging registers; frozen while a check runs so the verdict
	// and the stored copy come from the same values
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			job_r <= 8'h0;
			del_r <= 1'b0;
			mode_r <= 2'h0;
			type_r <= 16'h0;
			ident_r <= 32'h0;
			hdr_r <= '0;
			mcode_r <= '0;
			incr_r <= 32'h0;
			path_r <= 32'h0;
			revs_r <= 16'h0;
			trav_r <= 32'h0;
			prot_r <= 32'h0;
		end else if (wr && idle) begin
			if (paddr == `DSV_OFF_CTRL) begin
				job_r <= pwdata[`DSV_CTRL_JOB_LSB +: 8];
				del_r <= pwdata[`DSV_CTRL_DEL];
			end else if (paddr == `DSV_OFF_MODE) begin
				mode_r <= pwdata[1:0];
			end else if (paddr == `DSV_OFF_TYPE) begin
				type_r <= pwdata[15:0];
			end else if (paddr == `DSV_OFF_IDENT) begin
				ident_r <= pwdata;
			end else if (paddr == `DSV_OFF_HDR) begin
				hdr_r <= pwdata;
			end else if (paddr == `DSV_OFF_MCODE) begin
				mcode_r <= pwdata;
			end else if (paddr == `DSV_OFF_INCR) begin
				incr_r <= pwdata;
			end else if (paddr == `DSV_OFF_PATH) begin
				path_r <= pwdata;
			end else if (paddr == `DSV_OFF_REVS) begin
				revs_r <= pwdata[15:0];
			end else if (paddr == `DSV_OFF_TRAV) begin
				trav_r <= pwdata;
			end else if (paddr == `DSV_OFF_PROT) begin
				prot_r <= pwdata;
			end
		end
	end

	// ===========================================================
	// Checker: first failing check in priority order wins
	always_comb begin
		logic [7:0] ax;
		logic ax_ok, clash, ssi, src_ok;
		logic [47:0] range;
		dsv_enc_t kind;
		ax = hdr_r.axis;
		ax_ok = (ax >= 8'h1) && (ax <= 8'(NUM_AXES));
		clash = 1'b0;
		for (int i = 1; i <= NUM_AXES; i++) begin
			if (mach_valid_r[i] && mach_num_r[i] == hdr_r.set_num && ax != 8'(i)) begin
				clash = 1'b1;
			end
			if (type_r == `DSV_TYPE_SYS && mach_valid_r[i] && mach_num_r[i] == hdr_r.set_num) begin
				clash = 1'b1;
			end
		end
		kind = enc_kind(mcode_r.enc_type);
		ssi = (kind == DSV_ENC_SINGLE) || (kind == DSV_ENC_MULTI);
		src_ok = (mcode_r.enc_type == 4'h8) ? (mach_valid_r[1] && mach_incr_r[1]) : (mach_valid_r[2] && mach_incr_r[2]);
		range = path_r * {16'h0, revs_r};
		chk_err = 8'h0;
		if (del_r) begin
			if (mode_r != `DSV_MODE_PROG && mode_r != `DSV_MODE_CTRL) chk_err = `DSV_E_MODE;
		end else if (job_r != `DSV_JOB_OUT && job_r != `DSV_JOB_IN) begin
			chk_err = `DSV_E_JOB;
		end else if (mode_r != `DSV_MODE_PROG && mode_r != `DSV_MODE_CTRL) begin
			chk_err = `DSV_E_MODE;
		end else if (type_r != `DSV_TYPE_SYS && type_r != `DSV_TYPE_MACH && type_r != `DSV_TYPE_CAM &&
				type_r != `DSV_TYPE_TSET && type_r != `DSV_TYPE_TLIST) begin
			chk_err = `DSV_E_TYPE;
		end else if (ident_r != `DSV_IDENT) begin
			chk_err = `DSV_E_IDENT;
		end else if (type_r == `DSV_TYPE_SYS) begin
			if (hdr_r.set_num == 8'h0 || clash) chk_err = `DSV_E_NUM;
			else if (hdr_r.int_line > `DSV_MAX_LINE) chk_err = `DSV_E_8;
			else if (|mach_valid_r && hdr_r.int_line != sys_line_r) chk_err = `DSV_E_9;
			else if (|mach_valid_r && hdr_r.module_num != sys_mod_r) chk_err = `DSV_E_10;
		end else if (type_r == `DSV_TYPE_MACH) begin
			if (!ax_ok) chk_err = `DSV_E_AXIS;
			else if (hdr_r.set_num == 8'h0 || clash) chk_err = `DSV_E_NUM;
			else if (mach_valid_r[ax] && mach_num_r[ax] != hdr_r.set_num) chk_err = `DSV_E_AXNUM;
			else if (mach_valid_r[ax] && mach_prot_r[ax] != prot_r) chk_err = `DSV_E_AXNUM;
			else if (hdr_r.module_num == 8'h0 || !sys_valid_r || hdr_r.module_num != sys_mod_r) begin
				chk_err = `DSV_E_MODNUM;
			end else if (mcode_r.meas < 4'h1 || mcode_r.meas > 4'h3) chk_err = `DSV_E_8;
			else if (mcode_r.func < 4'h1 || mcode_r.func > 4'h2) chk_err = `DSV_E_9;
			else if (mcode_r.accuracy < 4'h1 || mcode_r.accuracy > 4'h4) chk_err = `DSV_E_10;
			else if (mcode_r.rev_irq && !mcode_r.rotary) chk_err = `DSV_E_REVIRQ;
			else if (mcode_r.coord < 4'h1 || mcode_r.coord > 4'h3) chk_err = `DSV_E_COORD;
			else if (kind == DSV_ENC_BAD) chk_err = `DSV_E_ENC;
			else if (mcode_r.enc_type >= 4'h8 && (ax != 8'h3 || !src_ok)) chk_err = `DSV_E_ENC;
			else if ((kind == DSV_ENC_SINGLE && (incr_r[0] || incr_r == 32'h0)) ||
					(kind == DSV_ENC_MULTI && (!is_pow2(incr_r) || incr_r > `DSV_MAX_INCR)) ||
					(kind == DSV_ENC_INCR && (incr_r == 32'h0 || incr_r > `DSV_MAX_INCR))) begin
				chk_err = `DSV_E_INCR;
			end else if (path_r == 32'h0 || path_r > `DSV_MAX_PATH) chk_err = `DSV_E_PATH;
			else if (revs_r == 16'h0 || revs_r > `DSV_MAX_REVS ||
					(kind == DSV_ENC_MULTI && !is_pow2({16'h0, revs_r})) ||
					(kind == DSV_ENC_INCR && revs_r != 16'h1)) begin
				chk_err = `DSV_E_REVS;
			end else if (ssi && (range < {16'h0, trav_r} || (mcode_r.rotary && range != {16'h0, trav_r}))) begin
				chk_err = `DSV_E_RANGE;
			end
		end
	end

	// ===========================================================
	// Sequencer: a write of the go bit starts one check cycle
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			DSV_IDLE: begin
				if (wr && paddr == `DSV_OFF_CTRL && pwdata[`DSV_CTRL_GO]) state_nxt = DSV_CHECK;
			end
			DSV_CHECK: begin
				if (chk_err == 8'h0 && (del_r || job_r == `DSV_JOB_IN)) state_nxt = DSV_COMMIT;
				else state_nxt = DSV_IDLE;
			end
			DSV_COMMIT: begin
				state_nxt = DSV_IDLE;
			end
			default: begin
				state_nxt = DSV_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= DSV_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Verdict of every check lands in the mailbox byte
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			err_r <= `DSV_RST_ERR;
		end else if (state_r == DSV_CHECK) begin
			err_r <= chk_err;
		end
	end

	// ===========================================================
	// Stored set state; only touched from a clean commit
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sys_valid_r <= 1'b0;
			sys_num_r <= 8'h0;
			sys_line_r <= 8'h0;
			sys_mod_r <= 8'h0;
		end else if (state_r == DSV_COMMIT && !del_r && type_r == `DSV_TYPE_SYS) begin
			sys_valid_r <= 1'b1;
			sys_num_r <= hdr_r.set_num;
			sys_line_r <= hdr_r.int_line;
			sys_mod_r <= hdr_r.module_num;
		end
	end

	// Deletion clears all machine data, which unlocks line and module
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mach_valid_r <= '0;
			mach_incr_r <= '0;
			for (int i = 1; i <= NUM_AXES; i++) begin
				mach_num_r[i] <= 8'h0;
				mach_prot_r[i] <= 32'h0;
			end
		end else if (state_r == DSV_COMMIT) begin
			if (del_r) begin
				mach_valid_r <= '0;
			end else if (type_r == `DSV_TYPE_MACH) begin
				mach_valid_r[hdr_r.axis] <= 1'b1;
				mach_incr_r[hdr_r.axis] <= (enc_kind(mcode_r.enc_type) == DSV_ENC_INCR);
				mach_num_r[hdr_r.axis] <= hdr_r.set_num;
				mach_prot_r[hdr_r.axis] <= prot_r;
			end
		end
	end

	// ===========================================================
	// Outputs
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign mbox_err_code = err_r;
	assign seq_state = state_r;

	// ===========================================================
	// Assertions
	default clocking dsv_cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	logic job_ok, mode_ok;
	assign job_ok = (job_r == `DSV_JOB_OUT) || (job_r == `DSV_JOB_IN);
	assign mode_ok = (mode_r == `DSV_MODE_PROG) || (mode_r == `DSV_MODE_CTRL);

	a_job_reject: assert property (state_r == DSV_CHECK && !del_r && !job_ok |=> err_r == 8'hC8)
		else $error("bad job code not answered with 200");
	a_mode_reject: assert property (state_r == DSV_CHECK && (del_r || job_ok) && !mode_ok
			|=> err_r == 8'hFD && state_r == DSV_IDLE)
		else $error("entry outside allowed mode not refused");
	a_type_check: assert property (state_r == DSV_CHECK && !del_r && job_ok && mode_ok
			&& type_r == 16'h0 |=> err_r == 8'h01)
		else $error("unknown set type not answered with 1");
	a_ident_check: assert property (state_r == DSV_CHECK && !del_r && job_ok && mode_ok &&
			type_r == `DSV_TYPE_SYS && ident_r != `DSV_IDENT |=> err_r == 8'h02)
		else $error("identity mismatch not answered with 2");
	a_line_range: assert property (state_r == DSV_CHECK && chk_err == 8'h0 && type_r == `DSV_TYPE_SYS
			&& !del_r |-> hdr_r.int_line <= 8'h04)
		else $error("interrupt line above 4 accepted");
	a_line_lock: assert property (state_r == DSV_CHECK && !del_r && type_r == `DSV_TYPE_SYS
			&& |mach_valid_r && chk_err == 8'h0 |-> hdr_r.int_line == sys_line_r && hdr_r.module_num == sys_mod_r)
		else $error("locked line or module changed");
	a_axis_range: assert property (state_r == DSV_COMMIT && !del_r && type_r == `DSV_TYPE_MACH
			|-> hdr_r.axis >= 8'h1 && hdr_r.axis <= 8'h3 && err_r != 8'h06)
		else $error("machine data stored for bad axis");
	a_no_store: assert property (state_r == DSV_CHECK && chk_err != 8'h0 |=> $stable(mach_valid_r) &&
			$stable(sys_valid_r) && $stable(sys_mod_r) && $stable(sys_num_r) ##1 $stable(mach_valid_r))
		else $error("rejected set changed stored state");
	a_mailbox: assert property (state_r == DSV_CHECK |=> mbox_err_code == $past(chk_err))
		else $error("mailbox byte does not hold verdict");
	a_commit_seq: assert property (state_r == DSV_CHECK && chk_err == 8'h0 && job_r == `DSV_JOB_IN
			&& !del_r |=> state_r == DSV_COMMIT ##1 state_r == DSV_IDLE)
		else $error("clean input set not committed");

endmodule

//--- dsv_defs.svh
// Register offsets, field positions, reset values and check limits of the data set validator
`ifndef DSV_DEFS_SVH
`define DSV_DEFS_SVH

// ===========================================================
// Register offsets (byte addresses)
`define DSV_OFF_CTRL 8'h00
`define DSV_OFF_MODE 8'h04
`define DSV_OFF_TYPE 8'h08
`define DSV_OFF_IDENT 8'h0C
`define DSV_OFF_HDR 8'h10
`define DSV_OFF_MCODE 8'h14
`define DSV_OFF_INCR 8'h18
`define DSV_OFF_PATH 8'h1C
`define DSV_OFF_REVS 8'h20
`define DSV_OFF_TRAV 8'h24
`define DSV_OFF_PROT 8'h28
`define DSV_OFF_STATUS 8'h2C

// ===========================================================
// Field positions
`define DSV_CTRL_GO 0
`define DSV_CTRL_DEL 1
`define DSV_CTRL_JOB_LSB 8
`define DSV_ST_BUSY 8
`define DSV_ST_SYS 9
`define DSV_ST_MACH_LSB 10

// ===========================================================
// Reset values and codes
`define DSV_RST_ERR 8'h00
`define DSV_JOB_OUT 8'h40
`define DSV_JOB_IN 8'h41
`define DSV_MODE_PROG 2'h1
`define DSV_MODE_CTRL 2'h2
`define DSV_TYPE_SYS 16'h4944
`define DSV_TYPE_MACH 16'h4D44
`define DSV_TYPE_CAM 16'h4E53
`define DSV_TYPE_TSET 16'h5A53
`define DSV_TYPE_TLIST 16'h5A4C
`define DSV_IDENT 32'h20414243 // Arbitrary identity value; only the leading space byte is fixed
`define DSV_MAX_LINE 8'h04
`define DSV_MAX_INCR 32'h02000000
`define DSV_MAX_PATH 32'h05F5E100
`define DSV_MAX_REVS 16'h1000

// ===========================================================
// Error numbers
`define DSV_E_TYPE 8'h01
`define DSV_E_IDENT 8'h02
`define DSV_E_NUM 8'h03
`define DSV_E_AXNUM 8'h04
`define DSV_E_MODNUM 8'h05
`define DSV_E_AXIS 8'h06
`define DSV_E_8 8'h08
`define DSV_E_9 8'h09
`define DSV_E_10 8'h0A
`define DSV_E_REVIRQ 8'h0C
`define DSV_E_COORD 8'h10
`define DSV_E_ENC 8'h14
`define DSV_E_INCR 8'h16
`define DSV_E_PATH 8'h17
`define DSV_E_REVS 8'h18
`define DSV_E_RANGE 8'h1C
`define DSV_E_JOB 8'hC8
`define DSV_E_MODE 8'hFD

`endif

//--- dsv_pkg.sv
// Types shared by the data set validator
package dsv_pkg;

	// ===========================================================
	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		DSV_IDLE = 3'h1,
		DSV_CHECK = 3'h2,
		DSV_COMMIT = 3'h4
	} dsv_state_t;

	// Encoder families derived from the encoder type code
	typedef enum logic [1:0] {
		DSV_ENC_INCR = 2'h0,
		DSV_ENC_SINGLE = 2'h1,
		DSV_ENC_MULTI = 2'h2,
		DSV_ENC_BAD = 2'h3
	} dsv_enc_t;

	// Header word of a data set
	typedef struct packed {
		logic [7:0] int_line;
		logic [7:0] axis;
		logic [7:0] module_num;
		logic [7:0] set_num;
	} dsv_hdr_t;

	// Machine data code word
	typedef struct packed {
		logic [9:0] rsv;
		logic rev_irq;
		logic rotary;
		logic [3:0] enc_type;
		logic [3:0] coord;
		logic [3:0] accuracy;
		logic [3:0] func;
		logic [3:0] meas;
	} dsv_mcode_t;

endpackage

//--- dsv_host.sv
// Host model: APB master that stages data sets and reads back the error byte
`include "dsv_defs.svh"

module dsv_host (
	input wire logic sys_clk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] last_kind; // Error numbers mean different things per kind
	int tmo_cnt;

	// ===========================================================
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		last_kind = 16'h0000;
		tmo_cnt = 0;
	end

	// One transfer, held until pready is seen high at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1);
		if (n != 2) tmo_cnt++; // Answer is due in the second access cycle
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a; // Released lines must not keep the old value
		pwdata <= ~d;
		if (w && a == `DSV_OFF_TYPE) last_kind = d[15:0];
	endtask

	// Error byte of the last submission, from the mailbox byte
	task automatic err_rd(output logic [7:0] code);
		logic [31:0] r;
		logic e;
		xfer(1'b0, `DSV_OFF_STATUS, 32'h00000000, r, e);
		code = r[7:0];
	endtask
endmodule

//--- testbench.sv
// Self-checking testbench of the data set validator
`include "dsv_defs.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import dsv_pkg::*;
	logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, err_v;
	logic [7:0] paddr, mbox_err_code;
	logic [31:0] pwdata, prdata, rd_v, idn, hdr, mcode, incr, path, revs, trav, prot;
	logic [15:0] ty;
	logic [2:0] map;
	dsv_state_t seq_state;
	int error_cnt, n_checks;

	dsv_validator i_dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mbox_err_code(mbox_err_code), .seq_state(seq_state));
	dsv_host i_host (.sys_clk(sys_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	// ===========================================================
	// Clock, 100 ns period
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Verdict seen both at the port and in the mailbox byte
	task automatic chk_err(input logic [7:0] exp);
		logic [7:0] code;
		i_host.err_rd(code);
		chk(32'(code), 32'(exp), "mailbox error");
		chk(32'(mbox_err_code), 32'(exp), "port error");
		chk(32'(i_host.last_kind), 32'(ty), "kind of last set");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, rd_v, err_v);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		i_host.xfer(1'b0, a, 32'h00000000, d, err_v);
	endtask

	// ===========================================================
	// Stage a whole set, start the check, wait for idle, judge
	task automatic go(input logic [7:0] job, input logic del, input logic [7:0] exp);
		logic [7:0] offs [9] = '{`DSV_OFF_TYPE, `DSV_OFF_IDENT, `DSV_OFF_HDR, `DSV_OFF_MCODE, `DSV_OFF_INCR,
			`DSV_OFF_PATH, `DSV_OFF_REVS, `DSV_OFF_TRAV, `DSV_OFF_PROT};
		logic [31:0] v [9];
		int n;
		v = '{{16'h0000, ty}, idn, hdr, mcode, incr, path, revs, trav, prot};
		foreach (offs[i]) wr(offs[i], v[i]);
		wr(`DSV_OFF_CTRL, {16'h0000, job, 6'h00, del, 1'b1});
		n = 0;
		do begin
			rd(`DSV_OFF_STATUS, rd_v);
			n++;
		end while (rd_v[8] !== 1'b0 && n < 20);
		chk(32'(rd_v[8]), 32'h00000000, "busy clears");
		chk_err(exp);
	endtask

	// Machine set with the given fields; stored axes must match map
	task automatic mt(input logic [31:0] h, m, i, p, r, input logic [7:0] e);
		hdr = h;
		mcode = m;
		incr = i;
		path = p;
		revs = r;
		ty = `DSV_TYPE_MACH;
		go(`DSV_JOB_IN, 1'b0, e);
		rd(`DSV_OFF_STATUS, rd_v);
		chk(32'(rd_v[12:10]), 32'(map), "stored axes");
	endtask

	task automatic t_reset();
		chk(32'(mbox_err_code), 32'h00000000, "reset error byte");
		chk(32'(seq_state), 32'h00000001, "reset state");
		wr(`DSV_OFF_STATUS, 32'hFFFFFFFF); // Read-only: must not stick
		rd(`DSV_OFF_STATUS, rd_v);
		chk(rd_v, 32'h00000000, "status");
		rd(8'h30, rd_v);
		chk(32'(err_v), 32'h00000001, "unmapped slverr");
		chk(rd_v, 32'h00000000, "unmapped data");
		$display("test reset done");
	endtask

	task automatic t_job();
		logic [7:0] jobs [4] = '{8'h00, 8'h3F, 8'h42, 8'hFF};
		ty = `DSV_TYPE_CAM;
		wr(`DSV_OFF_MODE, 32'h00000000);
		go(`DSV_JOB_IN, 1'b0, `DSV_E_MODE);
		wr(`DSV_OFF_MODE, 32'h00000003);
		go(`DSV_JOB_IN, 1'b1, `DSV_E_MODE);
		wr(`DSV_OFF_MODE, {30'h0, `DSV_MODE_CTRL});
		go(`DSV_JOB_OUT, 1'b0, 8'h00);
		wr(`DSV_OFF_MODE, {30'h0, `DSV_MODE_PROG});
		foreach (jobs[i]) go(jobs[i], 1'b0, `DSV_E_JOB);
		go(`DSV_JOB_IN, 1'b0, 8'h00);
		$display("test job done");
	endtask

	task automatic t_type();
		logic [15:0] kinds [3] = '{`DSV_TYPE_CAM, `DSV_TYPE_TSET, `DSV_TYPE_TLIST};
		ty = 16'h4142;
		go(`DSV_JOB_IN, 1'b0, `DSV_E_TYPE);
		foreach (kinds[i]) begin
			ty = kinds[i];
			go(`DSV_JOB_IN, 1'b0, 8'h00);
		end
		idn = 32'h00414243; // Leading space missing
		go(`DSV_JOB_IN, 1'b0, `DSV_E_IDENT);
		idn = `DSV_IDENT;
		$display("test type done");
	endtask

	task automatic t_ident();
		ty = `DSV_TYPE_SYS;
		hdr = 32'h04000500;
		go(`DSV_JOB_IN, 1'b0, `DSV_E_NUM);
		hdr = 32'h05000501;
		go(`DSV_JOB_IN, 1'b0, `DSV_E_8);
		rd(`DSV_OFF_STATUS, rd_v);
		chk(32'(rd_v[9]), 32'h00000000, "ident stored");
		hdr = 32'h04000501;
		go(`DSV_JOB_IN, 1'b0, 8'h00);
		rd(`DSV_OFF_STATUS, rd_v);
		chk(32'(rd_v[9]), 32'h00000001, "ident stored");
		$display("test ident done");
	endtask

	task automatic t_mach();
		map = 3'b001;
		mt(32'h0001050A, 32'h00011111, 1000, 1000, 1, 8'h00);
		mt(32'h0001050A, 32'h00011111, 1000, 1000, 1, 8'h00);
		mt(32'h0004050B, 32'h00011111, 1000, 1000, 1, `DSV_E_AXIS);
		mt(32'h0002050A, 32'h00011111, 1000, 1000, 1, `DSV_E_NUM);
		mt(32'h00020500, 32'h00011111, 1000, 1000, 1, `DSV_E_NUM);
		mt(32'h0001050B, 32'h00011111, 1000, 1000, 1, `DSV_E_AXNUM);
		prot = 32'h00000001;
		mt(32'h0001050A, 32'h00011111, 1000, 1000, 1, `DSV_E_AXNUM);
		prot = 32'h00000000;
		mt(32'h0002060B, 32'h00011111, 1000, 1000, 1, `DSV_E_MODNUM);
		mt(32'h0002000B, 32'h00011111, 1000, 1000, 1, `DSV_E_MODNUM);
		mt(32'h0002050B, 32'h00011114, 1000, 1000, 1, `DSV_E_8);
		mt(32'h0002050B, 32'h00011131, 1000, 1000, 1, `DSV_E_9);
		mt(32'h0002050B, 32'h00011511, 1000, 1000, 1, `DSV_E_10);
		mt(32'h0002050B, 32'h00010111, 1000, 1000, 1, `DSV_E_COORD);
		mt(32'h0002050B, 32'h00314111, 1000, 1000, 1, `DSV_E_COORD);
		mt(32'h0002050B, 32'h00211111, 1000, 1000, 1, `DSV_E_REVIRQ);
		mt(32'h0002050B, 32'h000A1111, 1000, 1000, 1, `DSV_E_ENC);
		mt(32'h0002050B, 32'h00081111, 1000, 1000, 1, `DSV_E_ENC);
		mt(32'h0002050B, 32'h00011111, 0, 1000, 1, `DSV_E_INCR);
		mt(32'h0002050B, 32'h00011111, 32'h02000001, 1000, 1, `DSV_E_INCR);
		mt(32'h0002050B, 32'h00031111, 1001, 1000, 1, `DSV_E_INCR);
		mt(32'h0002050B, 32'h00051111, 1000, 1000, 1, `DSV_E_INCR);
		mt(32'h0002050B, 32'h00011111, 1000, 0, 1, `DSV_E_PATH);
		mt(32'h0002050B, 32'h00011111, 1000, 32'h05F5E101, 1, `DSV_E_PATH);
		mt(32'h0002050B, 32'h00011111, 1000, 1000, 2, `DSV_E_REVS);
		mt(32'h0002050B, 32'h00051111, 1024, 1000, 3, `DSV_E_REVS);
		mt(32'h0002050B, 32'h00051111, 1024, 1000, 8192, `DSV_E_REVS);
		trav = 2000;
		mt(32'h0002050B, 32'h00031111, 1024, 1000, 1, `DSV_E_RANGE);
		trav = 500;
		mt(32'h0002050B, 32'h00131111, 1024, 1000, 1, `DSV_E_RANGE);
		trav = 1000;
		map = 3'b011;
		mt(32'h0002050B, 32'h00331111, 1024, 1000, 1, 8'h00);
		mt(32'h0003050C, 32'h00091111, 1000, 1000, 1, `DSV_E_ENC);
		map = 3'b111;
		mt(32'h0003050C, 32'h00081111, 1000, 1000, 1, 8'h00);
		$display("test machine done");
	endtask

	task automatic t_lock();
		ty = `DSV_TYPE_SYS;
		hdr = 32'h04000B0A;
		go(`DSV_JOB_IN, 1'b0, `DSV_E_NUM);
		hdr = 32'h03000501;
		go(`DSV_JOB_IN, 1'b0, `DSV_E_9);
		hdr = 32'h04000601;
		go(`DSV_JOB_IN, 1'b0, `DSV_E_10);
		go(`DSV_JOB_IN, 1'b1, 8'h00);
		rd(`DSV_OFF_STATUS, rd_v);
		chk(32'(rd_v[12:9]), 32'h00000001, "after delete");
		hdr = 32'h03000601;
		go(`DSV_JOB_IN, 1'b0, 8'h00);
		$display("test lock done");
	endtask

	// ===========================================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		error_cnt = 0;
		n_checks = 0;
		idn = `DSV_IDENT;
		{ty, hdr, mcode, incr, path, revs, trav, prot, map} = '0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_job();
		t_type();
		t_ident();
		t_mach();
		t_lock();
		chk(32'(i_host.tmo_cnt), 32'h00000000, "bus hang");
		stop_test();
	end

	// Watchdog, far beyond the few thousand cycles the tests need
	initial begin
		#5000000;
		error_cnt++;
		stop_test();
	end
endmodule
